/* File: dpsc_device.sv */
// synthesizer end: input shift register and the four control latches
`include "dpsc_params.svh"
module dpsc_device (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial link
  dpsc_link_if.device link,
  // IF section controls
  output logic [13:0] if_ref_count,
  output logic [5:0] if_swallow_count,
  output logic [11:0] if_main_count,
  output logic [1:0] if_prescaler_sel,
  output logic [2:0] if_pump_current,
  output logic if_pump_tristate,
  output logic if_pd_polarity,
  output logic if_powerdown,
  // RF section controls
  output logic [13:0] rf_ref_count,
  output logic [5:0] rf_swallow_count,
  output logic [11:0] rf_main_count,
  output logic [1:0] rf_prescaler_sel,
  output logic [2:0] rf_pump_current,
  output logic rf_pump_tristate,
  output logic rf_pd_polarity,
  output logic rf_powerdown,
  output logic fastlock_resistor_switch,
  // set once every latch has been written since reset
  output logic all_latches_loaded
);
  logic sclk_level;
  logic sclk_rise;
  logic strobe_level;
  logic strobe_rise;
  logic data_level;
  dpsc_pkg::dpsc_word_t shift_reg;
  dpsc_pkg::dpsc_word_t if_ref_latch;
  dpsc_pkg::dpsc_word_t if_n_latch;
  dpsc_pkg::dpsc_word_t rf_ref_latch;
  dpsc_pkg::dpsc_word_t rf_n_latch;
  logic [3:0] loaded;
  logic [1:0] sel;
  logic [3:0] load_en;

  dpsc_sync u_sclk (.clock(clock), .resetn(resetn), .async_in(link.serial_clock),
    .level(sclk_level), .rise(sclk_rise));
  dpsc_sync u_strobe (.clock(clock), .resetn(resetn), .async_in(link.latch_strobe),
    .level(strobe_level), .rise(strobe_rise));
  // data gets the same two-flop delay so it lines up with the sampled clock edge
  dpsc_sync u_data (.clock(clock), .resetn(resetn), .async_in(link.serial_data_in),
    .level(data_level), .rise());

  // new bits enter at the bottom, so the first bit ends up as the msb
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= `DPSC_LATCH_RESET;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[`DPSC_WORD_BITS-2:0], data_level};
    end
  end

  assign sel = shift_reg[`DPSC_SEL_MSB:`DPSC_SEL_LSB];

  // one-hot load enable from the select bits; a shift and a strobe never
  // coincide on a legal link, so the strobe takes the register before this shift
  always_comb begin
    load_en = 4'h0;
    if (!strobe_rise) begin
      load_en = 4'h0;
    end else if (sel == `DPSC_SEL_IF_REF) begin
      load_en = 4'h1;
    end else if (sel == `DPSC_SEL_IF_N) begin
      load_en = 4'h2;
    end else if (sel == `DPSC_SEL_RF_REF) begin
      load_en = 4'h4;
    end else begin
      load_en = 4'h8;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      if_ref_latch <= `DPSC_LATCH_RESET;
    end else if (load_en[0]) begin
      if_ref_latch <= shift_reg;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      if_n_latch <= `DPSC_LATCH_RESET;
    end else if (load_en[1]) begin
      if_n_latch <= shift_reg;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rf_ref_latch <= `DPSC_LATCH_RESET;
    end else if (load_en[2]) begin
      rf_ref_latch <= shift_reg;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rf_n_latch <= `DPSC_LATCH_RESET;
    end else if (load_en[3]) begin
      rf_n_latch <= shift_reg;
    end
  end

  // sticky record of which latches have been written since reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loaded <= 4'h0;
    end else begin
      loaded <= loaded | load_en;
    end
  end

  // decoded controls are registered so every output leaves a flip-flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      if_ref_count <= 14'h0000;
      if_swallow_count <= 6'h00;
      if_main_count <= 12'h000;
      if_prescaler_sel <= 2'h0;
    end else begin
      if_ref_count <= if_ref_latch[`DPSC_R_MSB:`DPSC_R_LSB];
      if_swallow_count <= if_n_latch[`DPSC_A_MSB:`DPSC_A_LSB];
      if_main_count <= if_n_latch[`DPSC_B_MSB:`DPSC_B_LSB];
      if_prescaler_sel <= if_n_latch[`DPSC_PRESC_MSB:`DPSC_PRESC_LSB];
    end
  end

  // fastlock overrides the programmed current only while its bit stays set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      if_pump_current <= 3'h0;
      if_pump_tristate <= 1'b0;
      if_pd_polarity <= 1'b0;
      if_powerdown <= 1'b0;
    end else begin
      if_pump_tristate <= if_ref_latch[`DPSC_TRISTATE_BIT];
      if_pd_polarity <= if_ref_latch[`DPSC_PDPOL_BIT];
      if_powerdown <= if_n_latch[`DPSC_PWRDN_BIT];
      if (if_n_latch[`DPSC_FASTLOCK_BIT]) begin
        if_pump_current <= `DPSC_CP_MAX;
      end else begin
        if_pump_current <= if_ref_latch[`DPSC_CP_MSB:`DPSC_CP_LSB];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rf_ref_count <= 14'h0000;
      rf_swallow_count <= 6'h00;
      rf_main_count <= 12'h000;
      rf_prescaler_sel <= 2'h0;
    end else begin
      rf_ref_count <= rf_ref_latch[`DPSC_R_MSB:`DPSC_R_LSB];
      rf_swallow_count <= rf_n_latch[`DPSC_A_MSB:`DPSC_A_LSB];
      rf_main_count <= rf_n_latch[`DPSC_B_MSB:`DPSC_B_LSB];
      rf_prescaler_sel <= rf_n_latch[`DPSC_PRESC_MSB:`DPSC_PRESC_LSB];
    end
  end

  // the damping resistor switch follows the same bit as the current override
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rf_pump_current <= 3'h0;
      rf_pump_tristate <= 1'b0;
      rf_pd_polarity <= 1'b0;
      rf_powerdown <= 1'b0;
      fastlock_resistor_switch <= 1'b0;
    end else begin
      rf_pump_tristate <= rf_ref_latch[`DPSC_TRISTATE_BIT];
      rf_pd_polarity <= rf_ref_latch[`DPSC_PDPOL_BIT];
      rf_powerdown <= rf_n_latch[`DPSC_PWRDN_BIT];
      fastlock_resistor_switch <= rf_n_latch[`DPSC_FASTLOCK_BIT];
      if (rf_n_latch[`DPSC_FASTLOCK_BIT]) begin
        rf_pump_current <= `DPSC_CP_MAX;
      end else begin
        rf_pump_current <= rf_ref_latch[`DPSC_CP_MSB:`DPSC_CP_LSB];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      all_latches_loaded <= 1'b0;
    end else begin
      all_latches_loaded <= &loaded;
    end
  end
endmodule

/* File: dpsc_params.svh */
// timing counts, field positions and reset values of the serial control latches
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
`define DPSC_WORD_BITS 24
`define DPSC_SEL_MSB 1
`define DPSC_SEL_LSB 0
`define DPSC_SEL_IF_REF 2'h0
`define DPSC_SEL_IF_N 2'h1
`define DPSC_SEL_RF_REF 2'h2
`define DPSC_SEL_RF_N 2'h3
`define DPSC_A_LSB 2
`define DPSC_A_MSB 7
`define DPSC_B_LSB 8
`define DPSC_B_MSB 19
`define DPSC_PRESC_LSB 20
`define DPSC_PRESC_MSB 21
`define DPSC_PWRDN_BIT 22
`define DPSC_FASTLOCK_BIT 23
`define DPSC_R_LSB 2
`define DPSC_R_MSB 15
`define DPSC_PDPOL_BIT 17
`define DPSC_TRISTATE_BIT 18
`define DPSC_CP_LSB 21
`define DPSC_CP_MSB 23
`define DPSC_CP_MAX 3'h7
`define DPSC_LATCH_RESET 24'h000000
`define DPSC_SCLK_MAX_HZ 20000000
`define DPSC_CLK_HZ 10000000
// shortest half period of the generated serial clock, in clock cycles; keeps it at or below the maximum rate
`define DPSC_SCLK_HALF ((`DPSC_CLK_HZ + 2 * `DPSC_SCLK_MAX_HZ - 1) / (2 * `DPSC_SCLK_MAX_HZ))
`define DPSC_SCLK_HALF_MIN 4
`endif

/* File: dpsc_pkg.sv */
// word type shared by both ends of the serial control link, and the host writer states
package dpsc_pkg;
  typedef logic [23:0] dpsc_word_t;
  typedef enum logic [4:0] {
    DPSC_IDLE = 5'h01,
    DPSC_LOW = 5'h02,
    DPSC_HIGH = 5'h04,
    DPSC_STROBE = 5'h08,
    DPSC_DONE = 5'h10
  } dpsc_host_state_e;
endpackage

/* File: dpsc_link_if.sv */
// three-wire serial link between host and synthesizer control latches
interface dpsc_link_if;
  logic serial_clock;
  logic serial_data_in;
  logic latch_strobe;
  modport host (output serial_clock, output serial_data_in, output latch_strobe);
  modport device (input serial_clock, input serial_data_in, input latch_strobe);
endinterface

/* File: dpsc_sync.sv */
// two-flop synchroniser with a combinational rising-edge pulse
module dpsc_sync (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // asynchronous level in, synchronised level and rise out
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic meta;
  logic prev;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= async_in;
      level <= meta;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end
  assign rise = level & ~prev;
endmodule

/* File: dpsc_host.sv */
// host end: Avalon-MM command registers driving the three-wire serial writer
`include "dpsc_params.svh"
module dpsc_host #(
  parameter int HALF_PERIOD = `DPSC_SCLK_HALF_MIN
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial link
  dpsc_link_if.host link
);
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int HALF_USED = (HALF_PERIOD < `DPSC_SCLK_HALF) ? `DPSC_SCLK_HALF : HALF_PERIOD;

  dpsc_pkg::dpsc_host_state_e state;
  dpsc_pkg::dpsc_word_t word;
  dpsc_pkg::dpsc_word_t shifter;
  logic [4:0] bits_left;
  logic [15:0] tick;
  logic tick_done;
  logic busy;
  logic sent_count_busy;
  logic [7:0] sent_count;

  assign tick_done = (tick == 16'(HALF_USED - 1));
  assign busy = (state != dpsc_pkg::DPSC_IDLE);

  // bus slave: one-cycle wait on every access; write to data while busy is held off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      word <= `DPSC_LATCH_RESET;
    end else begin
      waitrequest <= 1'b1;
      if (waitrequest && (read || write)) begin
        if (write && address == ADDR_DATA) begin
          if (!busy && !sent_count_busy) begin
            word <= writedata[23:0];
            waitrequest <= 1'b0;
          end
        end else if (write) begin
          waitrequest <= 1'b0;
        end else if (address == ADDR_DATA) begin
          readdata <= {8'h00, word};
          waitrequest <= 1'b0;
        end else if (address == ADDR_STATUS) begin
          readdata <= {23'h000000, sent_count, busy};
          waitrequest <= 1'b0;
        end else begin
          readdata <= 32'h00000000;
          waitrequest <= 1'b0;
        end
      end
    end
  end

  // a start is flagged the cycle the write is accepted
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sent_count_busy <= 1'b0;
    end else begin
      sent_count_busy <= waitrequest && write && address == ADDR_DATA && !busy
        && !sent_count_busy;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick <= 16'h0000;
    end else if (state == dpsc_pkg::DPSC_IDLE || tick_done) begin
      tick <= 16'h0000;
    end else begin
      tick <= tick + 16'h0001;
    end
  end

  // strobe stays low across all 24 bits and rises after the last one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= dpsc_pkg::DPSC_IDLE;
      shifter <= `DPSC_LATCH_RESET;
      bits_left <= 5'h00;
      sent_count <= 8'h00;
      link.serial_clock <= 1'b0;
      link.serial_data_in <= 1'b0;
      link.latch_strobe <= 1'b0;
    end else begin
      case (state)
        dpsc_pkg::DPSC_IDLE: begin
          if (sent_count_busy) begin
            shifter <= {word[22:0], 1'b0};
            link.serial_data_in <= word[23];
            bits_left <= 5'(`DPSC_WORD_BITS);
            link.latch_strobe <= 1'b0;
            state <= dpsc_pkg::DPSC_LOW;
          end
        end
        dpsc_pkg::DPSC_LOW: begin
          if (tick_done) begin
            link.serial_clock <= 1'b1;
            bits_left <= bits_left - 5'h01;
            state <= dpsc_pkg::DPSC_HIGH;
          end
        end
        dpsc_pkg::DPSC_HIGH: begin
          if (tick_done) begin
            link.serial_clock <= 1'b0;
            if (bits_left == 5'h00) begin
              state <= dpsc_pkg::DPSC_STROBE;
            end else begin
              link.serial_data_in <= shifter[23];
              shifter <= {shifter[22:0], 1'b0};
              state <= dpsc_pkg::DPSC_LOW;
            end
          end
        end
        dpsc_pkg::DPSC_STROBE: begin
          if (tick_done) begin
            link.latch_strobe <= 1'b1;
            state <= dpsc_pkg::DPSC_DONE;
          end
        end
        dpsc_pkg::DPSC_DONE: begin
          if (tick_done) begin
            link.latch_strobe <= 1'b0;
            sent_count <= sent_count + 8'h01;
            state <= dpsc_pkg::DPSC_IDLE;
          end
        end
        default: state <= dpsc_pkg::DPSC_IDLE;
      endcase
    end
  end
endmodule

/* File: dpsc_link_props.sv */
// concurrent checks on the three-wire link and the fastlock outputs
module dpsc_link_props (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // link wires
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  // fastlock outputs
  input wire logic [2:0] rf_pump_current,
  input wire logic fastlock_resistor_switch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [5:0] rise_count;
  logic sclk_q;
  // counts serial clock rises since the strobe last dropped
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      rise_count <= 6'h00;
    end else begin
      sclk_q <= serial_clock;
      if (latch_strobe) rise_count <= 6'h00;
      else if (serial_clock && !sclk_q) rise_count <= rise_count + 6'h01;
    end
  end
  sequence strobe_pulse;
    latch_strobe [*4];
  endsequence
  sequence strobe_release;
    ##[1:8] !latch_strobe;
  endsequence
  strobe_width_a: assert property ($rose(latch_strobe) |-> strobe_pulse ##0 strobe_release)
    else $error("strobe pulse has wrong width");
  strobe_quiet_a: assert property (latch_strobe |-> !serial_clock)
    else $error("serial clock high while strobe high");
  sclk_high_a: assert property ($rose(serial_clock) |-> serial_clock [*4])
    else $error("serial clock high phase too short");
  sclk_low_a: assert property ($fell(serial_clock) |-> !serial_clock [*4])
    else $error("serial clock low phase too short");
  data_hold_a: assert property (serial_clock |-> $stable(serial_data_in))
    else $error("serial data moved while clock high");
  word_bits_a: assert property ($rose(latch_strobe) |-> rise_count == 6'h18)
    else $error("strobe after wrong bit count");
  fastlock_max_a: assert property (fastlock_resistor_switch |-> rf_pump_current == 3'h7)
    else $error("fastlock without maximum pump current");
  latch_change_a: assert property ($changed(fastlock_resistor_switch) |->
      $past(latch_strobe) || $past(latch_strobe, 2) || $past(latch_strobe, 3))
    else $error("latch output changed without strobe");
endmodule

/* File: dual_pll_serial_control_latches_tb.sv */
// self-checking bench: host and device joined over the serial link
`include "dpsc_params.svh"
module dual_pll_serial_control_latches_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, read, write, waitrequest, if_pump_tristate, if_pd_polarity, if_powerdown;
  logic [3:0] address;
  logic [31:0] writedata, readdata;
  logic [13:0] if_ref_count, rf_ref_count;
  logic [5:0] if_swallow_count, rf_swallow_count;
  logic [11:0] if_main_count, rf_main_count;
  logic [1:0] if_prescaler_sel, rf_prescaler_sel;
  logic [2:0] if_pump_current, rf_pump_current;
  logic rf_pump_tristate, rf_pd_polarity, rf_powerdown, fastlock_resistor_switch;
  logic all_latches_loaded;
  logic [23:0] lat [4];
  int fail_count, compares, sent;
  dpsc_link_if link ();
  dpsc_host #(.HALF_PERIOD(4)) dpsc_host_i (.clock, .resetn, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .link(link));
  dpsc_device dpsc_device_i (.clock, .resetn, .link(link), .if_ref_count, .if_swallow_count,
    .if_main_count, .if_prescaler_sel, .if_pump_current, .if_pump_tristate, .if_pd_polarity,
    .if_powerdown, .rf_ref_count, .rf_swallow_count, .rf_main_count, .rf_prescaler_sel,
    .rf_pump_current, .rf_pump_tristate, .rf_pd_polarity, .rf_powerdown,
    .fastlock_resistor_switch, .all_latches_loaded);
  dpsc_link_props dpsc_link_props_i (.clock, .resetn, .serial_clock(link.serial_clock),
    .serial_data_in(link.serial_data_in), .latch_strobe(link.latch_strobe),
    .rf_pump_current, .fastlock_resistor_switch);
  always #50 clock = ~clock;
  // one side's outputs as the latches should set them
  function automatic logic [39:0] exp_side(input logic [23:0] r, input logic [23:0] n);
    return {r[15:2], n[7:2], n[19:8], n[21:20], n[23] ? `DPSC_CP_MAX : r[23:21], r[18],
      r[`DPSC_PDPOL_BIT],
      n[22]};
  endfunction
  task automatic end_sim;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 4000);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 4000) begin
      fail_count++;
      end_sim();
    end
  endtask
  task automatic send(input logic [23:0] w);
    logic [31:0] q;
    bus(1'b1, 4'h0, {8'h00, w}, q);
    lat[w[1:0]] = w;
    sent++;
  endtask
  // waits for the writer to go idle, then for the latch update
  task automatic settle_check;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h4, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (n >= 500) begin
      fail_count++;
      end_sim();
    end
    repeat (6) @(posedge clock);
    check({24'h0, if_ref_count, if_swallow_count, if_main_count, if_prescaler_sel,
      if_pump_current, if_pump_tristate, if_pd_polarity, if_powerdown},
      {24'h0, exp_side(lat[0], lat[1])});
    check({23'h0, rf_ref_count, rf_swallow_count, rf_main_count, rf_prescaler_sel,
      rf_pump_current, rf_pump_tristate, rf_pd_polarity, rf_powerdown, fastlock_resistor_switch},
      {23'h0, exp_side(lat[2], lat[3]), lat[3][23]});
  endtask
  initial begin
    logic [31:0] r, q;
    logic [23:0] corner [6];
    corner = '{24'h040000, 24'h800001, 24'hA4FFFE, 24'hBFFFFF, 24'h7FFFFD, 24'h000003};
    clock = 1'b0;
    resetn = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    lat = '{default: 24'h0};
    void'($urandom(32'h10E39A10));
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    settle_check();
    check({63'h0, all_latches_loaded}, 64'h0);
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      r = $urandom;
      send({r[23:2], k[1:0]});
      if (k % 4 == 3) begin
        settle_check();
        check({63'h0, all_latches_loaded}, 64'h1);
      end
    end
    $display("test random back-to-back done");
    foreach (corner[i]) begin
      send(corner[i]);
      settle_check();
    end
    $display("test fastlock and tristate done");
    bus(1'b1, 4'hC, 32'h00FFFFFF, q);
    settle_check();
    bus(1'b0, 4'h8, 32'h0, q);
    check(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    check(q, {23'h0, sent[7:0], 1'b0});
    bus(1'b0, 4'h0, 32'h0, q);
    check(q[23:0], corner[5]);
    $display("test registers done");
    end_sim();
  end
endmodule
